// [hw/pmr_pkg.sv]
// Constants and state type for the packed min/max/MAC rounding unit.
package pmr_pkg;
  // Operation kinds presented on opKind.
  localparam logic [2:0] OP_MAC  = 3'h0;
  localparam logic [2:0] OP_MAXW = 3'h1;
  localparam logic [2:0] OP_MINW = 3'h2;
  localparam logic [2:0] OP_MAXB = 3'h3;
  localparam logic [2:0] OP_MINB = 3'h4;
  localparam logic [2:0] OP_MAXH = 3'h5;
  localparam logic [2:0] OP_MINH = 3'h6;
  localparam logic [2:0] OP_CRRD = 3'h7;
  // Operand pairings for the two products.
  localparam logic [1:0] PAIR_UU_LL = 2'h0;
  localparam logic [1:0] PAIR_UL_LU = 2'h1;
  localparam logic [1:0] PAIR_UL_LL = 2'h2;
  localparam logic [1:0] PAIR_LU_UU = 2'h3;
  // Arithmetic constants.
  localparam logic [33:0] ROUND_ADD = 34'h000008000;
  localparam logic [31:0] Q_MAX     = 32'h7fffffff;
  localparam logic [15:0] HALF_NEG  = 16'h8000;
  localparam logic [15:0] SAT_POS   = 16'h7fff;
  // Register map, byte addresses.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_SFR0   = 8'h10;
  localparam int         SFR_COUNT  = 4;
  // Status bit positions.
  localparam int FLAG_V   = 0;
  localparam int FLAG_SV  = 1;
  localparam int FLAG_AV  = 2;
  localparam int FLAG_SAV = 3;
  // Reset values.
  localparam logic [31:0] SFR_RST = 32'h00000000;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                  resultValid;
    logic [31:0]           result;
    logic                  ov;
    logic                  sv;
    logic                  aov;
    logic                  sticky_advanced_range_flag;
    logic [3:0][31:0]      sfr;
    logic                  awGot;
    logic                  wGot;
    logic [7:0]            awAddr;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic                  bValid;
    logic [1:0]            bResp;
    logic                  rValid;
    logic [31:0]           rData;
    logic [1:0]            rResp;
  } pmr_state_t;
endpackage

// [hw/pmr_unit.sv]
// Packed rounding MAC, min/max select and core register read datapath.
//
// Functional notes
// - Upper lane adds product, lower lane subtracts.
// - Four selectable halfword operand pairings.
// - Shift operand one doubles each product.
// - Fractional square of most negative saturates.
// - Overflow flags computed on final lane results.
// - Saturating variant clamps each lane separately.
// - Rounding adds 0x8000, upper half kept.
// - Signed word max, immediate sign extended.
// - Unsigned word max, immediate zero extended.
// - Signed word min, immediate sign extended.
// - Byte max per lane, signed or unsigned.
// - Byte min per lane, signed or unsigned.
// - Halfword max per lane, signed or unsigned.
// - Halfword min per lane, signed or unsigned.
// - Core read copies special register at offset.
// - Core read allowed at any privilege.
// - Core read of a GPR is undefined.
`timescale 1ns/1ps
module pmr_unit (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        opValid,
  input  wire logic [2:0]  opKind,
  input  wire logic        opUnsigned,
  input  wire logic        opSaturate,
  input  wire logic [1:0]  pairSel,
  input  wire logic        shiftOne,
  input  wire logic        useImm,
  input  wire logic [8:0]  imm9,
  input  wire logic [15:0] imm16,
  input  wire logic [31:0] opA,
  input  wire logic [31:0] opB,
  input  wire logic [31:0] opAcc,
  output logic             resultValid,
  output logic [31:0]      result,
  output logic             flagOverflow,
  output logic             flagStickyOverflow,
  output logic             flagAdvanced,
  output logic             flagStickyAdvanced,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ********************************************************
  // Helper functions
  // ********************************************************

  // Q15 product, the fractional square of -1 pinned to the top.
  function automatic logic [31:0] mulQ(input logic [15:0] x,
                                       input logic [15:0] y,
                                       input logic        n);
    logic signed [31:0] xs;
    logic signed [31:0] ys;
    logic [31:0]        p;
    xs = signed'({{16{x[15]}}, x});
    ys = signed'({{16{y[15]}}, y});
    p  = 32'(xs * ys);
    if (n && x == pmr_pkg::HALF_NEG && y == pmr_pkg::HALF_NEG) begin
      mulQ = pmr_pkg::Q_MAX;
    end else if (n) begin
      mulQ = {p[30:0], 1'b0};
    end else begin
      mulQ = p;
    end
  endfunction

  // Accumulate one lane at 34 bits so no carry is lost, then round.
  function automatic logic [33:0] laneSum(input logic [15:0] acc,
                                          input logic [31:0] p,
                                          input logic        sub);
    logic [33:0] a;
    logic [33:0] pe;
    a  = {{2{acc[15]}}, acc, 16'h0000};
    pe = {{2{p[31]}}, p};
    laneSum = 34'((sub ? a - pe : a + pe) + pmr_pkg::ROUND_ADD);
  endfunction

  // True when a lane sum left the 32-bit signed range.
  function automatic logic laneOv(input logic [33:0] s);
    laneOv = !(s[33] == s[32] && s[32] == s[31]);
  endfunction

  // Lane result: upper half, or the clamp value when saturating.
  function automatic logic [15:0] laneOut(input logic [33:0] s,
                                          input logic        sat);
    if (sat && laneOv(s)) begin
      laneOut = s[33] ? pmr_pkg::HALF_NEG : pmr_pkg::SAT_POS;
    end else begin
      laneOut = s[31:16];
    end
  endfunction

  // Lane-wise greater or lesser pick; width 0 word, 1 byte, 2 half.
  function automatic logic [31:0] pick(input logic [31:0] a,
                                       input logic [31:0] b,
                                       input logic [1:0]  w,
                                       input logic        isMax,
                                       input logic        uns);
    logic signed [8:0]  ab;
    logic signed [8:0]  bb;
    logic signed [16:0] ah;
    logic signed [16:0] bh;
    logic signed [32:0] aw;
    logic signed [32:0] bw;
    pick = b;
    if (w == 2'h1) begin
      for (int i = 0; i < 4; i++) begin
        ab = signed'({uns ? 1'b0 : a[8*i+7], a[8*i+:8]});
        bb = signed'({uns ? 1'b0 : b[8*i+7], b[8*i+:8]});
        if (isMax ? ab > bb : ab < bb) begin
          pick[8*i+:8] = a[8*i+:8];
        end
      end
    end else if (w == 2'h2) begin
      for (int i = 0; i < 2; i++) begin
        ah = signed'({uns ? 1'b0 : a[16*i+15], a[16*i+:16]});
        bh = signed'({uns ? 1'b0 : b[16*i+15], b[16*i+:16]});
        if (isMax ? ah > bh : ah < bh) begin
          pick[16*i+:16] = a[16*i+:16];
        end
      end
    end else begin
      aw = signed'({uns ? 1'b0 : a[31], a});
      bw = signed'({uns ? 1'b0 : b[31], b});
      if (isMax ? aw > bw : aw < bw) begin
        pick = a;
      end
    end
  endfunction

  // Register index from a bus address; SFR_COUNT+1 means unmapped.
  function automatic logic [2:0] regIdx(input logic [7:0] addr);
    if (addr == pmr_pkg::OFF_STATUS) begin
      regIdx = 3'(pmr_pkg::SFR_COUNT);
    end else if (addr[7:4] == pmr_pkg::OFF_SFR0[7:4] && addr[1:0] == 2'h0) begin
      regIdx = {1'b0, addr[3:2]};
    end else begin
      regIdx = 3'(pmr_pkg::SFR_COUNT + 1);
    end
  endfunction

  // ********************************************************
  // Datapath
  // ********************************************************

  pmr_pkg::pmr_state_t st;
  pmr_pkg::pmr_state_t next_st;

  logic [15:0] aH, aL, bH, bL;
  logic [15:0] m1x, m1y, m2x, m2y;
  logic [31:0] pHi, pLo, bOperand, statusWord;
  logic [33:0] sHi, sLo;
  logic        ovHi, ovLo, avNow, awHs, wHs, arHs;

  // Operand pairing for the upper and lower products.
  always_comb begin
    aH = opA[31:16];
    aL = opA[15:0];
    bH = opB[31:16];
    bL = opB[15:0];
    case (pairSel)
      pmr_pkg::PAIR_UU_LL: begin
        m1x = aH; m1y = bH; m2x = aL; m2y = bL;
      end
      pmr_pkg::PAIR_UL_LU: begin
        m1x = aH; m1y = bL; m2x = aL; m2y = bH;
      end
      pmr_pkg::PAIR_UL_LL: begin
        m1x = aH; m1y = bL; m2x = aL; m2y = bL;
      end
      default: begin
        m1x = aL; m1y = bH; m2x = aH; m2y = bH;
      end
    endcase
  end

  // Upper lane adds, lower lane subtracts, both rounded.
  assign pHi   = mulQ(m1x, m1y, shiftOne);
  assign pLo   = mulQ(m2x, m2y, shiftOne);
  assign sHi   = laneSum(opAcc[31:16], pHi, 1'b0);
  assign sLo   = laneSum(opAcc[15:0], pLo, 1'b1);
  assign ovHi  = laneOv(sHi);
  assign ovLo  = laneOv(sLo);
  // Advanced overflow looks at the unsaturated final sums.
  assign avNow = (sHi[31] ^ sHi[30]) | (sLo[31] ^ sLo[30]);

  // Immediate replaces the second word operand, extended by signedness.
  assign bOperand = !useImm ? opB :
                    opUnsigned ? {23'h0, imm9} : {{23{imm9[8]}}, imm9};

  assign statusWord = {28'h0, st.sticky_advanced_range_flag, st.aov, st.sv, st.ov};
  assign awHs = s_axi_awvalid && s_axi_awready;
  assign wHs  = s_axi_wvalid && s_axi_wready;
  assign arHs = s_axi_arvalid && s_axi_arready;

  // Next-state of the whole unit: operation, flags and bus slave.
  always_comb begin
    next_st = st;
    next_st.resultValid = opValid;
    if (opValid) begin
      case (opKind)
        pmr_pkg::OP_MAC: begin
          next_st.result = {laneOut(sHi, opSaturate), laneOut(sLo, opSaturate)};
          next_st.ov  = ovHi | ovLo;
          next_st.aov = avNow;
        end
        pmr_pkg::OP_MAXW: next_st.result = pick(opA, bOperand, 2'h0, 1'b1, opUnsigned);
        pmr_pkg::OP_MINW: next_st.result = pick(opA, bOperand, 2'h0, 1'b0, opUnsigned);
        pmr_pkg::OP_MAXB: next_st.result = pick(opA, opB, 2'h1, 1'b1, opUnsigned);
        pmr_pkg::OP_MINB: next_st.result = pick(opA, opB, 2'h1, 1'b0, opUnsigned);
        pmr_pkg::OP_MAXH: next_st.result = pick(opA, opB, 2'h2, 1'b1, opUnsigned);
        pmr_pkg::OP_MINH: next_st.result = pick(opA, opB, 2'h2, 1'b0, opUnsigned);
        default: begin
          // No privilege check exists; offsets outside the bank read zero,
          // which also covers the undefined GPR case.
          next_st.result = (imm16[15:4] == 12'h000)
                           ? st.sfr[imm16[3:2]] : 32'h0;
        end
      endcase
    end
    // Software may clear sticky bits; a set in the same cycle wins.
    if (st.awGot && st.wGot && regIdx(st.awAddr) == 3'(pmr_pkg::SFR_COUNT)) begin
      if (st.wStrb[0] && st.wData[pmr_pkg::FLAG_SV]) next_st.sv = 1'b0;
      if (st.wStrb[0] && st.wData[pmr_pkg::FLAG_SAV]) next_st.sticky_advanced_range_flag = 1'b0;
    end
    if (opValid && opKind == pmr_pkg::OP_MAC) begin
      next_st.sv  = next_st.sv | ovHi | ovLo;
      next_st.sticky_advanced_range_flag = next_st.sticky_advanced_range_flag | avNow;
    end
    // Write channel: address and data taken in either order.
    if (awHs) begin
      next_st.awGot  = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (wHs) begin
      next_st.wGot  = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.awGot && st.wGot) begin
      next_st.awGot  = 1'b0;
      next_st.wGot   = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = pmr_pkg::RESP_OKAY;
      if (regIdx(st.awAddr) < 3'(pmr_pkg::SFR_COUNT)) begin
        for (int k = 0; k < 4; k++) begin
          if (st.wStrb[k]) next_st.sfr[st.awAddr[3:2]][8*k+:8] = st.wData[8*k+:8];
        end
      end else if (regIdx(st.awAddr) != 3'(pmr_pkg::SFR_COUNT)) begin
        next_st.bResp = pmr_pkg::RESP_SLVERR;
      end
    end
    if (st.bValid && s_axi_bready) next_st.bValid = 1'b0;
    // Read channel: one cycle to data.
    if (arHs) begin
      next_st.rValid = 1'b1;
      next_st.rResp  = pmr_pkg::RESP_OKAY;
      next_st.rData  = 32'h0;
      if (regIdx(s_axi_araddr) < 3'(pmr_pkg::SFR_COUNT)) begin
        next_st.rData = st.sfr[s_axi_araddr[3:2]];
      end else if (regIdx(s_axi_araddr) == 3'(pmr_pkg::SFR_COUNT)) begin
        next_st.rData = statusWord;
      end else begin
        next_st.rResp = pmr_pkg::RESP_SLVERR;
      end
    end else if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st     <= '0;
      st.sfr <= {4{pmr_pkg::SFR_RST}};
    end else begin
      st <= next_st;
    end
  end

  // Outputs; channel readies stall while a response is pending.
  assign resultValid        = st.resultValid;
  assign result             = st.result;
  assign flagOverflow       = st.ov;
  assign flagStickyOverflow = st.sv;
  assign flagAdvanced       = st.aov;
  assign flagStickyAdvanced = st.sticky_advanced_range_flag;
  assign s_axi_awready = !st.awGot && !st.bValid;
  assign s_axi_wready  = !st.wGot && !st.bValid;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = !st.rValid;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;

  // ********************************************************
  // Assertions
  // ********************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sMacSat;
    opValid && opKind == pmr_pkg::OP_MAC && opSaturate;
  endsequence
  sequence sSelOp;
    opValid && opKind != pmr_pkg::OP_MAC;
  endsequence

  a_q_square: assert property (shiftOne && m1x == m1y
    && m1x == pmr_pkg::HALF_NEG |-> pHi == pmr_pkg::Q_MAX)
    else $error("fractional square not pinned");
  a_sat_hi: assert property (sMacSat ##0 ovHi |=> result[31:16]
    == ($past(sHi[33]) ? pmr_pkg::HALF_NEG : pmr_pkg::SAT_POS))
    else $error("upper lane not clamped");
  a_round_lo: assert property (opValid && !ovLo
    && opKind == pmr_pkg::OP_MAC |=> result[15:0] == $past(sLo[31:16]))
    else $error("lower lane rounding wrong");
  a_ov_flag: assert property (opValid
    && opKind == pmr_pkg::OP_MAC |=> flagOverflow == $past(ovHi | ovLo))
    else $error("overflow flag wrong");
  a_flags_keep: assert property (sSelOp |=> $stable(flagOverflow)
    && $stable(flagAdvanced))
    else $error("select changed flags");
  a_sticky_hold: assert property (flagStickyOverflow
    && !(st.awGot && st.wGot) |=> flagStickyOverflow)
    else $error("sticky overflow dropped");
  a_max_word: assert property (opValid && !opUnsigned
    && opKind == pmr_pkg::OP_MAXW |=> result == ($signed($past(opA))
    > $signed($past(bOperand)) ? $past(opA) : $past(bOperand)))
    else $error("signed word max wrong");
  a_min_ubyte: assert property (opValid && opUnsigned
    && opKind == pmr_pkg::OP_MINB |=> result[31:24] <= $past(opA[31:24])
    && result[31:24] <= $past(opB[31:24]))
    else $error("unsigned byte min wrong");
  a_write_resp: assert property (st.awGot && st.wGot |=> s_axi_bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule // pmr_unit

// [tb/pmr_unit_tb.sv]
// Self-checking testbench for the packed min/max/MAC rounding unit.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module pmr_unit_tb;
  // ****************************************************************
  // Signals and device under test
  // ****************************************************************
  logic        clk = 1'b0, rst_n = 1'b0, opValid = 1'b0;
  logic        opUnsigned = 1'b0, opSaturate = 1'b0, shiftOne = 1'b0;
  logic        useImm = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [1:0]  pairSel = 2'h0;
  logic [2:0]  opKind = 3'h0;
  logic [8:0]  imm9 = 9'h0;
  logic [15:0] imm16 = 16'h0;
  logic [31:0] opA = 32'h0, opB = 32'h0, opAcc = 32'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        resultValid, flagOverflow, flagStickyOverflow;
  logic        flagAdvanced, flagStickyAdvanced, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] result, s_axi_rdata;
  int          mismatches = 0, checks = 0;
  logic        mOv = 1'b0, mSv = 1'b0, mAv = 1'b0, mSav = 1'b0;
  logic [31:0] sfr [4];

  pmr_unit dut (
    .clk, .rst_n, .opValid, .opKind, .opUnsigned, .opSaturate, .pairSel,
    .shiftOne, .useImm, .imm9, .imm16, .opA, .opB, .opAcc, .resultValid,
    .result, .flagOverflow, .flagStickyOverflow, .flagAdvanced,
    .flagStickyAdvanced, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // A 4 ns period gives the 250 MHz core clock.
  always #2 clk = ~clk;

  // ****************************************************************
  // Reference functions
  // ****************************************************************
  // Signed halfword product; the doubled square of the most negative
  // value would wrap, so it is pinned to the largest positive value.
  function automatic logic [31:0] prod(input logic [15:0] x,
                                       input logic [15:0] y,
                                       input logic        n);
    logic [31:0] q;
    q = $signed(x) * $signed(y);
    if (n && x == 16'h8000 && y == 16'h8000)
      return 32'h7fffffff;
    return n ? q << 1 : q;
  endfunction

  // One lane: accumulate, round, judge range and clamp if asked.
  function automatic logic [15:0] lane(input logic [15:0] acc,
      input logic [31:0] p, input logic sub, input logic sat,
      output logic v, output logic av);
    logic [33:0] s, pe;
    pe = {{2{p[31]}}, p};
    s = {{2{acc[15]}}, acc, 16'h0} + (sub ? -pe : pe) + 34'h8000;
    v = s[33:31] != 3'h0 && s[33:31] != 3'h7;
    av = s[31] ^ s[30];
    return (sat && v) ? (s[33] ? 16'h8000 : 16'h7fff) : s[31:16];
  endfunction

  // Greater-than on a lane of width w; flipping the top bit lets the
  // unsigned compare order signed values.
  function automatic logic gt(input logic [31:0] x, input logic [31:0] y,
                              input int w, input logic u);
    logic [31:0] f;
    f = u ? 32'h0 : 32'h1 << (w - 1);
    return (x ^ f) > (y ^ f);
  endfunction

  // Lane-wise select of the greater or lesser value.
  function automatic logic [31:0] minmax(input logic [2:0] k,
      input logic u, input logic [31:0] a, input logic [31:0] b);
    int w;
    logic mx;
    logic [31:0] m, x, y, r;
    w = k <= pmr_pkg::OP_MINW ? 32 : k <= pmr_pkg::OP_MINB ? 8 : 16;
    mx = k == pmr_pkg::OP_MAXW || k == pmr_pkg::OP_MAXB ||
         k == pmr_pkg::OP_MAXH;
    m = w == 32 ? 32'hffffffff : (32'h1 << w) - 32'h1;
    r = 32'h0;
    for (int i = 0; i < 32 / w; i++) begin
      x = (a >> (i * w)) & m;
      y = (b >> (i * w)) & m;
      r = r | (((gt(x, y, w, u) == mx && x != y) ? x : y) << (i * w));
    end
    return r;
  endfunction

  // ****************************************************************
  // Bus and operation tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    $display("mismatch at %0t: bus answer never came", $time);
    end_of_test();
  endtask

  // Address and data go out together; each drops once it is taken.
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    logic aw, w, b;
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 20) hang();
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    logic ar, v;
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 20) hang();
  endtask

  // Issue one operation and check the answer one cycle later.
  task automatic runOp(input logic [2:0] k, input logic u, input logic s,
      input logic [1:0] ps, input logic n, input logic im,
      input logic [8:0] i9, input logic [15:0] i16, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] c);
    logic [31:0] e, ph, pl, bs;
    logic vh, vl, ah, al;
    @(posedge clk);
    opKind <= k;
    opUnsigned <= u;
    opSaturate <= s;
    pairSel <= ps;
    shiftOne <= n;
    useImm <= im;
    imm9 <= i9;
    imm16 <= i16;
    opA <= a;
    opB <= b;
    opAcc <= c;
    opValid <= 1'b1;
    @(posedge clk);
    opValid <= 1'b0;
    ph = prod(ps[1] ? (ps[0] ? a[15:0] : a[31:16]) : a[31:16],
              ps == 2'h0 || ps == 2'h3 ? b[31:16] : b[15:0], n);
    pl = prod(ps == 2'h3 ? a[31:16] : a[15:0],
              ps[0] ? b[31:16] : b[15:0], n);
    bs = !im || k > pmr_pkg::OP_MINW ? b : u ? {23'h0, i9}
         : {{23{i9[8]}}, i9};
    if (k == pmr_pkg::OP_MAC) begin
      e[31:16] = lane(c[31:16], ph, 1'b0, s, vh, ah);
      e[15:0] = lane(c[15:0], pl, 1'b1, s, vl, al);
      mOv = vh | vl;
      mAv = ah | al;
      mSv = mSv | mOv;
      mSav = mSav | mAv;
    end else if (k == pmr_pkg::OP_CRRD)
      e = i16[15:4] == 12'h0 ? sfr[i16[3:2]] : 32'h0;
    else
      e = minmax(k, u, a, bs);
    @(negedge clk);
    `CHK(resultValid, 1'b1)
    if (k == pmr_pkg::OP_MAC)
      `CHK(result, e)
    else if (k == pmr_pkg::OP_CRRD)
      `CHK(result, e)
    else
      `CHK(result, e)
    `CHK({flagOverflow, flagAdvanced}, {mOv, mAv})
    `CHK({flagStickyOverflow, flagStickyAdvanced}, {mSv, mSav})
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    #200000;
    hang();
  end

  initial begin : main
    logic [31:0] d, a, b;
    logic [1:0] r;
    d = $urandom(32'h72bb);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // Fill the special register bank, then read it as an operation.
    for (int i = 0; i < 4; i++) begin
      sfr[i] = $urandom;
      axiWr(pmr_pkg::OFF_SFR0 + 8'(4 * i), sfr[i], r);
      `CHK(r, pmr_pkg::RESP_OKAY)
    end
    for (int i = 0; i < 5; i++)
      runOp(pmr_pkg::OP_CRRD, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 9'h0,
            16'(4 * i), 32'h0, 32'h0, 32'h0);
    axiWr(8'h40, $urandom, r);
    `CHK(r, pmr_pkg::RESP_SLVERR)
    axiRd(8'h40, d, r);
    `CHK({d, r}, {32'h0, pmr_pkg::RESP_SLVERR})
    $display("test core register read done");
    // Most negative squares drive both lanes out of range, opposite ways.
    for (int i = 0; i < 16; i++)
      runOp(pmr_pkg::OP_MAC, 1'b0, i[0], i[2:1], i[3], 1'b0, 9'h0, 16'h0,
            32'h80008000, 32'h80008000, 32'h7fff8000);
    repeat (300) begin
      d = $urandom;
      runOp(pmr_pkg::OP_MAC, d[0], d[1], d[3:2], d[4], d[5], d[14:6],
            d[30:15], $urandom, $urandom, $urandom);
    end
    $display("test mac done");
    // Every select kind, signed and unsigned, with byte edge values.
    for (int k = 1; k < 7; k++)
      for (int j = 0; j < 40; j++) begin
        d = $urandom;
        a = j < 4 ? (j[0] ? 32'h7f80ff00 : 32'h807f80ff) : $urandom;
        b = j < 4 ? (j[0] ? 32'h807f80ff : 32'h7f80ff00) : $urandom;
        runOp(3'(k), j < 4 ? j[1] : d[0], d[11], d[13:12], d[14], d[10],
              d[9:1], d[30:15], a, b, $urandom);
      end
    $display("test select done");
    // Status view, then clearing the sticky bits from software.
    axiRd(pmr_pkg::OFF_STATUS, d, r);
    `CHK({d, r}, {28'h0, mSav, mAv, mSv, mOv,
         pmr_pkg::RESP_OKAY})
    axiWr(pmr_pkg::OFF_STATUS, 32'hf, r);
    `CHK(r, pmr_pkg::RESP_OKAY)
    mSv = 1'b0;
    mSav = 1'b0;
    @(negedge clk);
    `CHK({flagOverflow, flagStickyOverflow, flagAdvanced, flagStickyAdvanced},
         {mOv, 1'b0, mAv, 1'b0})
    runOp(pmr_pkg::OP_MAC, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0, 9'h0, 16'h0,
          32'h80008000, 32'h80008000, 32'h7fff8000);
    $display("test status done");
    // A reset in mid-run must clear the flags and the register bank.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK({resultValid, flagOverflow, flagStickyOverflow, flagAdvanced,
         flagStickyAdvanced}, 5'h00)
    {mOv, mSv, mAv, mSav} = 4'h0;
    for (int i = 0; i < 4; i++)
      sfr[i] = 32'h0;
    runOp(pmr_pkg::OP_CRRD, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 9'h0,
          16'h0008, 32'h0, 32'h0, 32'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule // pmr_unit_tb
